// ==== sdp_cfg.svh ====
// Constants for the dual-port synchronous RAM port logic.
// Assumes inclusion by bare name from the design modules.
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

// Address width for a 16K-deep array, data width of one word
`define SDP_ADDR_W      14
`define SDP_DATA_W      9
`define SDP_NUM_PORTS   2

// Reset values of the captured controls: port deselected, read, no strobes
`define SDP_RST_CSL     1'b1
`define SDP_RST_CSH     1'b0
`define SDP_RST_RNW     1'b1
`define SDP_RST_STROBE  1'b1

// Clock and port-to-port figures, kept for reference only; no logic uses them
`define SDP_CLK_PERIOD_NS  100
`define SDP_WR_TO_RD_NS    24

`endif

// ==== sdp_pkg.sv ====
// Types shared by the dual-port RAM port logic.
// Assumes sdp_cfg.svh is on the include path.
package sdp_pkg;

    // Power state of one port's output circuitry
    typedef enum logic {
        SDP_PWR_DOWN,
        SDP_PWR_UP
    } sdp_pwr_t;

    // Decoded output latency of one port
    typedef enum logic {
        SDP_LAT_FLOW,
        SDP_LAT_PIPE
    } sdp_lat_t;

endpackage : sdp_pkg

// ==== sdp_port_if.sv ====
// Carrier between a port's input capture stage and the shared array core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface sdp_port_if #(
    parameter int AW = 14,
    parameter int DW = 9
);
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          sel;
    logic          pdown;
    logic          write;
    logic          read;

    modport ctr  (output addr, output wdata, output sel, output pdown,
                  output write, output read);
    modport core (input addr, input wdata, input sel, input pdown,
                  input write, input read);
endinterface : sdp_port_if

// ==== sdp_port_regs.sv ====
// Input capture registers and address counter of one RAM port.
// Assumes inputs are produced by host logic on core_clk.
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_port_regs
    import sdp_pkg::*;
#(
    parameter int ADDR_W = `SDP_ADDR_W,
    parameter int DATA_W = `SDP_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              chip_select_low_active,
    input  wire logic              chip_select_high_active,
    input  wire logic              read_not_write,
    input  wire logic              address_load_strobe_n,
    input  wire logic              counter_advance_enable_n,
    input  wire logic              counter_clear_n,
    sdp_port_if.ctr                bus
);

    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic              csl_q, csl_d;
    logic              csh_q, csh_d;
    logic              rnw_q, rnw_d;
    logic              load_n_q, load_n_d;
    logic              adv_n_q, adv_n_d;
    logic              clr_n_q, clr_n_d;
    logic [ADDR_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] acc_addr;

    always_comb begin
        // RULE_01: capture all inputs
        addr_d   = ext_addr;
        wdata_d  = wr_data;
        csl_d    = chip_select_low_active;
        csh_d    = chip_select_high_active;
        rnw_d    = read_not_write;
        load_n_d = address_load_strobe_n;
        adv_n_d  = counter_advance_enable_n;
        clr_n_d  = counter_clear_n;
        // RULE_09: clear gives address zero
        if (!clr_n_q) begin
            acc_addr = '0;
        // RULE_04: load external address
        // RULE_05: strobe selects external address
        end else if (!load_n_q) begin
            acc_addr = addr_q;
        // RULE_06: advance to next address
        end else if (!adv_n_q) begin
            acc_addr = cnt_q + 1'b1;
        // RULE_07: hold address
        // RULE_08: stalled counter holds
        end else begin
            acc_addr = cnt_q;
        end
        // Counter tracks the access address so a later advance starts from it
        cnt_d = acc_addr;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q   <= '0;
            wdata_q  <= '0;
            csl_q    <= `SDP_RST_CSL;
            csh_q    <= `SDP_RST_CSH;
            rnw_q    <= `SDP_RST_RNW;
            load_n_q <= `SDP_RST_STROBE;
            adv_n_q  <= `SDP_RST_STROBE;
            clr_n_q  <= `SDP_RST_STROBE;
            cnt_q    <= '0;
        end else begin
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            csl_q    <= csl_d;
            csh_q    <= csh_d;
            rnw_q    <= rnw_d;
            load_n_q <= load_n_d;
            adv_n_q  <= adv_n_d;
            clr_n_q  <= clr_n_d;
            cnt_q    <= cnt_d;
        end
    end

    assign bus.addr  = acc_addr;
    assign bus.wdata = wdata_q;
    assign bus.sel   = !csl_q && csh_q;
    // Only this one combination powers down; other deselects just float
    assign bus.pdown = csl_q && !csh_q;
    assign bus.write = bus.sel && !rnw_q;
    assign bus.read  = bus.sel && rnw_q;

endmodule : sdp_port_regs

// ==== sdp_dual_port_ram.sv ====
// Two-port synchronous RAM: shared array, per-port output stage.
// Assumes both hosts drive their ports synchronously to core_clk.
`timescale 1ns/1ps
`include "sdp_cfg.svh"
// Notes on behaviour
// RULE_01: All port inputs registered on rising edge; output enable, latency select are not.
// RULE_02: Write strobe timed internally from registered write.
// RULE_03: Output enable gates data asynchronously.
// RULE_04: Load strobe loads external address.
// RULE_05: Access address is external or counter.
// RULE_06: Advance increments address; write uses it.
// RULE_07: No load, no advance: address holds.
// RULE_08: Advance enable stalls the counter.
// RULE_09: Clear accesses address zero, no dead cycle.
// RULE_10: Output state follows previous cycle controls.
// RULE_11: Host rewrites location after write then idle.
// RULE_12: Deselect combination one cycle powers down.
// RULE_13: Pipelined outputs need two selected cycles.
// RULE_14: Host may expand depth using chip selects.
// RULE_15: Close same-address write-read: fixed delay.
// RULE_16: Wider separation: read valid after separation.
// RULE_17: Both ports identical.
// RULE_18: Latency select: high pipelined, low flow-through.
// RULE_19: Deselect floats outputs after next edge; pipelined outputs here float one edge later.
// RULE_20: Flow read same cycle; pipelined one later.
// RULE_21: One shared array for both ports.
module sdp_dual_port_ram
    import sdp_pkg::*;
#(
    parameter int ADDR_W = `SDP_ADDR_W,
    parameter int DATA_W = `SDP_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // Port A
    input  wire logic [ADDR_W-1:0] a_address,
    input  wire logic [DATA_W-1:0] a_data_in,
    output logic      [DATA_W-1:0] a_data_out,
    output logic                   a_data_oe,
    input  wire logic              a_chip_select_low_active,
    input  wire logic              a_chip_select_high_active,
    input  wire logic              a_read_not_write,
    input  wire logic              a_address_load_strobe_n,
    input  wire logic              a_counter_advance_enable_n,
    input  wire logic              a_counter_clear_n,
    input  wire logic              a_output_enable_n,
    input  wire logic              a_output_latency_select,
    output logic                   a_powered_down,
    // Port B
    input  wire logic [ADDR_W-1:0] b_address,
    input  wire logic [DATA_W-1:0] b_data_in,
    output logic      [DATA_W-1:0] b_data_out,
    output logic                   b_data_oe,
    input  wire logic              b_chip_select_low_active,
    input  wire logic              b_chip_select_high_active,
    input  wire logic              b_read_not_write,
    input  wire logic              b_address_load_strobe_n,
    input  wire logic              b_counter_advance_enable_n,
    input  wire logic              b_counter_clear_n,
    input  wire logic              b_output_enable_n,
    input  wire logic              b_output_latency_select,
    output logic                   b_powered_down
);

    localparam int NP    = `SDP_NUM_PORTS;
    localparam int DEPTH = 1 << ADDR_W;

    // RULE_21: single shared array
    logic [DATA_W-1:0] mem [DEPTH];

    // Per-port pin bundles, index 0 is port A
    logic [NP-1:0][ADDR_W-1:0] p_addr;
    logic [NP-1:0][DATA_W-1:0] p_din;
    logic [NP-1:0][DATA_W-1:0] p_dout;
    logic [NP-1:0]             p_oe;
    logic [NP-1:0]             p_csl;
    logic [NP-1:0]             p_csh;
    logic [NP-1:0]             p_rnw;
    logic [NP-1:0]             p_load_n;
    logic [NP-1:0]             p_adv_n;
    logic [NP-1:0]             p_clr_n;
    logic [NP-1:0]             p_oe_n;
    logic [NP-1:0]             p_lat;
    logic [NP-1:0]             p_pd;

    // Array-side view of each port
    logic [NP-1:0][ADDR_W-1:0] acc_addr;
    logic [NP-1:0][DATA_W-1:0] acc_wdata;
    logic [NP-1:0]             wr_strobe;
    logic [NP-1:0][DATA_W-1:0] flow_data;

    // Decodes the latency pin; used by both output stages
    function automatic sdp_lat_t lat_mode(input logic sel_pin);
        lat_mode = sel_pin ? SDP_LAT_PIPE : SDP_LAT_FLOW;
    endfunction : lat_mode

    assign p_addr[0]   = a_address;
    assign p_addr[1]   = b_address;
    assign p_din[0]    = a_data_in;
    assign p_din[1]    = b_data_in;
    assign p_csl[0]    = a_chip_select_low_active;
    assign p_csl[1]    = b_chip_select_low_active;
    assign p_csh[0]    = a_chip_select_high_active;
    assign p_csh[1]    = b_chip_select_high_active;
    assign p_rnw[0]    = a_read_not_write;
    assign p_rnw[1]    = b_read_not_write;
    assign p_load_n[0] = a_address_load_strobe_n;
    assign p_load_n[1] = b_address_load_strobe_n;
    assign p_adv_n[0]  = a_counter_advance_enable_n;
    assign p_adv_n[1]  = b_counter_advance_enable_n;
    assign p_clr_n[0]  = a_counter_clear_n;
    assign p_clr_n[1]  = b_counter_clear_n;
    assign p_oe_n[0]   = a_output_enable_n;
    assign p_oe_n[1]   = b_output_enable_n;
    assign p_lat[0]    = a_output_latency_select;
    assign p_lat[1]    = b_output_latency_select;

    assign a_data_out     = p_dout[0];
    assign b_data_out     = p_dout[1];
    assign a_data_oe      = p_oe[0];
    assign b_data_oe      = p_oe[1];
    assign a_powered_down = p_pd[0];
    assign b_powered_down = p_pd[1];

    // RULE_17: identical logic per port
    for (genvar i = 0; i < NP; i++) begin : gen_port
        sdp_port_if #(.AW(ADDR_W), .DW(DATA_W)) pif ();

        sdp_pwr_t          pwr_q, pwr_d;
        logic [DATA_W-1:0] pipe_q, pipe_d;
        logic              pipe_drive_q, pipe_drive_d;
        logic              drive;
        logic [DATA_W-1:0] out_data;

        sdp_port_regs #(
            .ADDR_W (ADDR_W),
            .DATA_W (DATA_W)
        ) u_regs (
            .core_clk                 (core_clk),
            .resetn                   (resetn),
            .ext_addr                 (p_addr[i]),
            .wr_data                  (p_din[i]),
            .chip_select_low_active   (p_csl[i]),
            .chip_select_high_active  (p_csh[i]),
            .read_not_write           (p_rnw[i]),
            .address_load_strobe_n    (p_load_n[i]),
            .counter_advance_enable_n (p_adv_n[i]),
            .counter_clear_n          (p_clr_n[i]),
            .bus                      (pif.ctr)
        );

        assign acc_addr[i]  = pif.addr;
        assign acc_wdata[i] = pif.wdata;
        // RULE_02: strobe from registered write
        assign wr_strobe[i] = pif.write;
        // RULE_20: flow data in capture cycle
        assign flow_data[i] = mem[pif.addr];

        always_comb begin
            pwr_d = pwr_q;
            // RULE_12: power-down combination
            if (pif.pdown) begin
                pwr_d = SDP_PWR_DOWN;
            end else if (pif.sel) begin
                pwr_d = SDP_PWR_UP;
            end
            // RULE_20: pipelined stage one later
            pipe_d       = flow_data[i];
            // RULE_13: needs a prior selected cycle
            pipe_drive_d = pif.read && (pwr_q == SDP_PWR_UP);
        end

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                pwr_q        <= SDP_PWR_DOWN;
                pipe_q       <= '0;
                pipe_drive_q <= 1'b0;
            end else begin
                pwr_q        <= pwr_d;
                pipe_q       <= pipe_d;
                pipe_drive_q <= pipe_drive_d;
            end
        end

        // RULE_10: drive from registered controls
        // RULE_19: deselect floats after edge
        // RULE_18: latency pin acts immediately
        always_comb begin
            unique case (lat_mode(p_lat[i]))
                SDP_LAT_PIPE: begin
                    drive    = pipe_drive_q;
                    out_data = pipe_q;
                end
                SDP_LAT_FLOW: begin
                    drive    = pif.read;
                    out_data = flow_data[i];
                end
            endcase
        end

        // RULE_03: enable gates asynchronously
        assign p_oe[i]   = drive && !p_oe_n[i];
        // Masked to zero whenever the port output is not enabled
        assign p_dout[i] = p_oe[i] ? out_data : '0;
        assign p_pd[i]   = (pwr_q == SDP_PWR_DOWN);
    end

    // RULE_02: write lands at the next edge
    // RULE_15: cross-port read valid next cycle
    // RULE_16: later reads see stored data
    // Port B is applied last, so it wins a same-address collision
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < NP; k++) begin
            if (wr_strobe[k]) begin
                mem[acc_addr[k]] <= acc_wdata[k];
            end
        end
    end

endmodule : sdp_dual_port_ram

// ==== sdp_host_model.sv ====
// Host model for one RAM port, driving its inputs at the falling edge.
// Assumes a free-running core_clk and one caller at a time.
`timescale 1ns/1ps
module sdp_host_model #(
    parameter int AW = 14,
    parameter int DW = 9
) (
    input  wire logic          core_clk,
    output logic      [AW-1:0] addr,
    output logic      [DW-1:0] din,
    output logic               csl,
    output logic               csh,
    output logic               rnw,
    output logic               ld_n,
    output logic               adv_n,
    output logic               clr_n,
    output logic               oe_n,
    output logic               lat
);
    // Start in the power-down combination with outputs gated off
    initial begin
        {csl, csh, rnw, ld_n, adv_n, clr_n, oe_n, lat} = 8'hBE;
        addr = '0;
        din = '0;
    end

    // Controls packed as csl csh rnw ld_n adv_n clr_n oe_n lat
    task automatic op(input logic [7:0] c, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(negedge core_clk);
        {csl, csh, rnw, ld_n, adv_n, clr_n, oe_n, lat} = c;
        addr = a;
        // Idle data toggles so a stale word never looks valid
        din = c[5] ? ~din : d;
    endtask : op

    task automatic wr_nop(input logic [AW-1:0] a, input logic [DW-1:0] d);
        op(8'h4C, a, d);
        op(8'hBC, a, d);
        op(8'h4C, a, d);
    endtask : wr_nop

    // bank select straight from the top address bit, no decode
    // Low bank uses the low-active enable, high bank the high-active one
    task automatic bank_rd(input logic [AW-1:0] a, input logic hi_bank);
        op({(hi_bank ? 1'b0 : a[AW-1]), (hi_bank ? a[AW-1] : 1'b1), 6'h2C}, a, '0);
    endtask : bank_rd
endmodule : sdp_host_model

// ==== sdp_dual_port_ram_assertions.sv ====
// Checker on the top ports of the RAM: port a timing plus the b gate.
// Assumes a bind into sdp_dual_port_ram; one clock, reset active low.
`timescale 1ns/1ps
module sdp_dual_port_ram_chk #(
    parameter int DATA_W = 9
) (
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic [DATA_W-1:0] a_data_out,
    input wire logic              a_data_oe,
    input wire logic              a_chip_select_low_active,
    input wire logic              a_chip_select_high_active,
    input wire logic              a_read_not_write,
    input wire logic              a_output_enable_n,
    input wire logic              a_output_latency_select,
    input wire logic              a_powered_down,
    input wire logic              b_output_enable_n,
    input wire logic              b_data_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire sel = !a_chip_select_low_active && a_chip_select_high_active;
    wire pdc = a_chip_select_low_active && !a_chip_select_high_active;
    wire rd  = sel && a_read_not_write;
    // Mode qualifiers hold oe_n low so the async gate cannot mask a fault
    wire fl  = !a_output_latency_select && !a_output_enable_n;
    wire pp  = a_output_latency_select && !a_output_enable_n;

    oe_gate_a: assert property (a_output_enable_n |-> !a_data_oe)
        else $error("port a drives with enable off");
    b_gate_a: assert property (b_output_enable_n |-> !b_data_oe)
        else $error("port b drives with enable off");
    idle_zero_a: assert property (!a_data_oe |-> a_data_out == '0)
        else $error("idle port a data not zero");
    power_down_a: assert property (pdc |-> ##[1:2] a_powered_down)
        else $error("port a did not power down");
    flow_drive_a: assert property (rd && fl ##1 fl |-> a_data_oe)
        else $error("flow read not driven");
    flow_float_a: assert property (!sel && fl ##1 fl |-> !a_data_oe)
        else $error("flow deselect still driven");
    pipe_float_a: assert property (!sel && pp ##1 pp |=> !pp || !a_data_oe)
        else $error("pipelined deselect still driven");
    pipe_wake_a: assert property (pdc && pp ##1 rd && pp ##1 rd && pp
        |=> (!pp || !a_data_oe) ##1 (!pp || a_data_oe))
        else $error("pipelined wake timing wrong");
endmodule : sdp_dual_port_ram_chk

// ==== sdp_dual_port_ram_bench.sv ====
// Bench for the dual-port RAM: two host models, scenario tasks, verdict.
// Assumes design, host model and checker files are compiled first.
`timescale 1ns/1ps
module sdp_dual_port_ram_bench;
    logic [13:0] a_address, b_address;
    logic [8:0]  a_data_in, b_data_in, a_data_out, b_data_out;
    logic        core_clk, resetn, a_data_oe, b_data_oe, a_powered_down, b_powered_down;
    logic        a_chip_select_low_active, a_chip_select_high_active, a_read_not_write;
    logic        b_chip_select_low_active, b_chip_select_high_active, b_read_not_write;
    logic        a_address_load_strobe_n, a_counter_advance_enable_n, a_counter_clear_n;
    logic        b_address_load_strobe_n, b_counter_advance_enable_n, b_counter_clear_n;
    logic        a_output_enable_n, a_output_latency_select;
    logic        b_output_enable_n, b_output_latency_select;
    int          failures = 0;
    int          tests_run = 0;

    sdp_dual_port_ram uut (
        .core_clk, .resetn, .a_address, .a_data_in, .a_data_out, .a_data_oe,
        .a_chip_select_low_active, .a_chip_select_high_active, .a_read_not_write,
        .a_address_load_strobe_n, .a_counter_advance_enable_n, .a_counter_clear_n,
        .a_output_enable_n, .a_output_latency_select, .a_powered_down,
        .b_address, .b_data_in, .b_data_out, .b_data_oe,
        .b_chip_select_low_active, .b_chip_select_high_active, .b_read_not_write,
        .b_address_load_strobe_n, .b_counter_advance_enable_n, .b_counter_clear_n,
        .b_output_enable_n, .b_output_latency_select, .b_powered_down
    );
    sdp_host_model h_a (
        .core_clk, .addr(a_address), .din(a_data_in), .csl(a_chip_select_low_active),
        .csh(a_chip_select_high_active), .rnw(a_read_not_write),
        .ld_n(a_address_load_strobe_n), .adv_n(a_counter_advance_enable_n),
        .clr_n(a_counter_clear_n), .oe_n(a_output_enable_n), .lat(a_output_latency_select)
    );
    sdp_host_model h_b (
        .core_clk, .addr(b_address), .din(b_data_in), .csl(b_chip_select_low_active),
        .csh(b_chip_select_high_active), .rnw(b_read_not_write),
        .ld_n(b_address_load_strobe_n), .adv_n(b_counter_advance_enable_n),
        .clr_n(b_counter_clear_n), .oe_n(b_output_enable_n), .lat(b_output_latency_select)
    );

    task automatic chk_d(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t data %h want %h", $time, got, exp);
        end
    endtask : chk_d
    task automatic chk_b(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t flag %b want %b", $time, got, exp);
        end
    endtask : chk_b
    task automatic summarize();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic t_reset();
        chk_b(a_data_oe, 1'b0);
        chk_b(a_powered_down, 1'b1);
        chk_b(b_powered_down, 1'b1);
    endtask : t_reset
    // Write on a, read back on b the cycle after the store
    task automatic t_share();
        h_a.wr_nop(14'h2AAA, 9'h1A5);
        h_b.op(8'h6C, 14'h2AAA, 9'h000);
        h_a.op(8'hBC, 14'h0000, 9'h000);
        chk_b(b_data_oe, 1'b1);
        chk_d(b_data_out, 9'h1A5);
    endtask : t_share
    // Advance past a loaded top-1 address, ignoring the external bus
    task automatic t_adv();
        h_a.op(8'h4C, 14'h3FFE, 9'h0C3);
        h_a.op(8'h54, 14'h0000, 9'h05A);
        h_a.op(8'h6C, 14'h3FFF, 9'h000);
        h_a.op(8'h6C, 14'h3FFE, 9'h000);
        chk_d(a_data_out, 9'h05A);
        h_a.op(8'hBC, 14'h0000, 9'h000);
        chk_d(a_data_out, 9'h0C3);
    endtask : t_adv
    task automatic t_hold();
        h_b.op(8'h6C, 14'h3FFF, 9'h000);
        h_b.op(8'h7C, 14'h0000, 9'h000);
        h_b.op(8'h7C, 14'h1111, 9'h000);
        chk_d(b_data_out, 9'h05A);
        h_b.op(8'hBC, 14'h0000, 9'h000);
        chk_d(b_data_out, 9'h05A);
    endtask : t_hold
    // Port b stores a fresh word that port a reads one edge later;
    // b then reads it pipelined and through a bank-decoded select
    task automatic t_cross();
        h_b.op(8'h4C, 14'h1555, 9'h0F0);
        h_a.op(8'h6C, 14'h1555, 9'h000);
        h_b.op(8'h7D, 14'h0000, 9'h000);
        chk_d(a_data_out, 9'h0F0);
        h_b.op(8'h7D, 14'h0000, 9'h000);
        chk_b(b_data_oe, 1'b0);
        h_b.op(8'h7D, 14'h0000, 9'h000);
        chk_d(b_data_out, 9'h0F0);
        h_b.bank_rd(14'h1555, 1'b1);
        h_b.bank_rd(14'h1555, 1'b0);
        chk_b(b_data_oe, 1'b0);
        h_b.op(8'hBC, 14'h0000, 9'h000);
        chk_d(b_data_out, 9'h0F0);
    endtask : t_cross
    task automatic t_clear();
        h_a.op(8'h6C, 14'h3FFE, 9'h000);
        h_a.op(8'h58, 14'h3FFF, 9'h133);
        h_a.op(8'h78, 14'h3FFF, 9'h000);
        h_a.op(8'hBC, 14'h0000, 9'h000);
        chk_d(a_data_out, 9'h133);
    endtask : t_clear
    task automatic t_pipe();
        h_a.op(8'hBD, 14'h0000, 9'h000);
        h_a.op(8'hBD, 14'h0000, 9'h000);
        chk_b(a_powered_down, 1'b1);
        h_a.op(8'h6D, 14'h3FFF, 9'h000);
        h_a.op(8'h6D, 14'h3FFF, 9'h000);
        h_a.op(8'h6D, 14'h3FFF, 9'h000);
        chk_b(a_data_oe, 1'b0);
        h_a.op(8'hBD, 14'h0000, 9'h000);
        chk_d(a_data_out, 9'h05A);
        chk_b(a_powered_down, 1'b0);
        h_a.op(8'hBD, 14'h0000, 9'h000);
        h_a.op(8'hBD, 14'h0000, 9'h000);
        chk_b(a_data_oe, 1'b0);
    endtask : t_pipe
    task automatic t_oe();
        h_a.op(8'h6C, 14'h2AAA, 9'h000);
        h_a.op(8'h7C, 14'h0000, 9'h000);
        chk_d(a_data_out, 9'h1A5);
        // Read still captured; only the asynchronous gate can drop the drive here
        h_a.op(8'h7E, 14'h0000, 9'h000);
        #1 chk_b(a_data_oe, 1'b0);
        h_a.op(8'h3C, 14'h0000, 9'h000);
        h_a.op(8'hBC, 14'h0000, 9'h000);
        chk_b(a_data_oe, 1'b0);
    endtask : t_oe

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        resetn = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset();
        resetn = 1'b1;
        t_share();
        t_adv();
        t_hold();
        t_cross();
        t_clear();
        t_pipe();
        t_oe();
        summarize();
    end
    // About 42 cycles expected; the limit leaves wide margin
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule : sdp_dual_port_ram_bench

bind sdp_dual_port_ram sdp_dual_port_ram_chk #(.DATA_W(DATA_W)) chk (
    .core_clk, .resetn, .a_data_out, .a_data_oe, .a_chip_select_low_active,
    .a_chip_select_high_active, .a_read_not_write, .a_output_enable_n,
    .a_output_latency_select, .a_powered_down, .b_output_enable_n, .b_data_oe
);
